/* File: core/iepr_cfg.svh */
// Register offsets, field positions and reset values for the enable/priority block
`ifndef IEPR_CFG_SVH
`define IEPR_CFG_SVH
`define IEPR_OFS_EN_A 12'h09b
`define IEPR_OFS_EN_B 12'h09c
`define IEPR_OFS_PRIO_HI 12'h0b7
`define IEPR_OFS_PRIO_LO 12'h0b8
`define IEPR_ADDR_EN_A 12'h26c
`define IEPR_ADDR_EN_B 12'h270
`define IEPR_ADDR_PRIO_HI 12'h2dc
`define IEPR_ADDR_PRIO_LO 12'h2e0
`define IEPR_OFS_CTRL 12'h100
`define IEPR_OFS_STAT 12'h104
`define IEPR_OFS_MASK 12'h108
`define IEPR_OFS_REQ 12'h10c
`define IEPR_OFS_LEVEL 12'h110
`define IEPR_RST_BYTE 8'h00
`define IEPR_RST_SRC 11'h000
`define IEPR_EN_A_MASK 8'hff
`define IEPR_EN_B_MASK 8'h07
`define IEPR_PRIO_MASK 8'h7f
`define IEPR_BIT_GLOBAL 0
`define IEPR_BIT_TIMER2 7
`define IEPR_BIT_SPI 6
`define IEPR_BIT_BRAKE 5
`define IEPR_BIT_WDT 4
`define IEPR_BIT_PWM 3
`define IEPR_BIT_CAP 2
`define IEPR_BIT_PIN 1
`define IEPR_BIT_I2C 0
`define IEPR_BIT_WAKE 2
`define IEPR_BIT_TIMER3 1
`define IEPR_BIT_UART1 0
`define IEPR_NSRC 11
`define IEPR_NCORE 7
`endif

/* File: core/iepr_pkg.sv */
// Types shared by the enable/priority block
package iepr_pkg;
  typedef logic [7:0] iepr_byte_t;
  typedef logic [1:0] iepr_level_t;
  typedef enum logic [1:0] {
    IEPR_ADDR = 2'b00,
    IEPR_DATA = 2'b01
  } iepr_phase_e;
endpackage

/* File: core/iepr_regs.sv */
// Extended enables and base priority registers behind an AHB-Lite slave
//
// What this block does
// - Global enable gates every source request.
// - Enable A bit 7 gates timer 2 overflow.
// - Enable A bit 6 gates OR of SPI flags.
// - Enable A bit 5 gates brake fault flag.
// - Enable A bit 4 gates watchdog flag.
// - Enable A bit 3 gates PWM period flag.
// - Enable A bit 2 gates any capture flag.
// - Enable A bit 1 gates any pin flag.
// - Enable A bit 0 gates I2C state/timeout.
// - Enable B has bits 2..0; bit 2 wake.
// - Enable B bit 1 gates timer 3 overflow.
// - Enable B bit 0 gates UART1 tx/rx.
// - All four registers reset to zero.
// - Priority low bits for seven core sources.
// - Priority high bits at matching positions.
// - Priority low bit 7 unimplemented.
// - Enable bits: 0 disabled, 1 enabled, RW.
`timescale 1ns/1ps
`include "iepr_cfg.svh"

module iepr_regs #(
  parameter int PIN_W = 8 // Width of the pin flag group
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [11:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  input wire logic timer2_overflow_flag, // Timer 2 overflow
  input wire logic spi_done_flag, // SPI transfer complete
  input wire logic spi_overrun_flag, // SPI overrun
  input wire logic spi_mode_fault, // SPI mode fault
  input wire logic brake_fault_flag, // Fault brake
  input wire logic watchdog_flag, // Watchdog
  input wire logic pwm_event_flag, // PWM period
  input wire logic [2:0] capture_flags, // Capture channels
  input wire logic [PIN_W-1:0] pin_flag_group, // Pin interrupt flags
  input wire logic i2c_state_flag, // I2C serial state change
  input wire logic i2c_timeout_flag, // I2C bus timeout
  input wire logic wake_timer_flag, // Wake-up timer
  input wire logic timer3_overflow_flag, // Timer 3 overflow
  input wire logic uart1_tx_flag, // UART1 transmit complete
  input wire logic uart1_rx_flag, // UART1 receive complete
  output logic [`IEPR_NSRC-1:0] src_req, // Gated requests per source
  output logic [2*`IEPR_NCORE-1:0] core_level, // 2-bit level per core src
  output logic irq // Interrupt to the system
);

  logic [7:0] en_a_reg;
  logic [7:0] en_b_reg;
  logic [7:0] prio_hi_reg;
  logic [7:0] prio_lo_reg;
  logic global_irq_en;
  logic [`IEPR_NSRC-1:0] stat_reg;
  logic [`IEPR_NSRC-1:0] mask_reg;
  logic [`IEPR_NSRC-1:0] raw_flag;
  logic [`IEPR_NSRC-1:0] src_en;
  logic [`IEPR_NSRC-1:0] req_next;
  logic [`IEPR_NSRC-1:0] req_prev_reg;
  iepr_pkg::iepr_phase_e phase_reg;
  logic wr_pend_reg;
  logic [11:0] addr_reg;
  logic [31:0] rd_next;
  logic acc;

  // Zero-wait slave: every access completes in its data phase
  assign acc = hsel && hready && htrans[1];

  // Raw flags grouped per source: enable A sources in bits 7..0, B above
  always_comb begin
    raw_flag[`IEPR_BIT_TIMER2] = timer2_overflow_flag;
    raw_flag[`IEPR_BIT_SPI] = spi_done_flag | spi_overrun_flag
      | spi_mode_fault;
    raw_flag[`IEPR_BIT_BRAKE] = brake_fault_flag;
    raw_flag[`IEPR_BIT_WDT] = watchdog_flag;
    raw_flag[`IEPR_BIT_PWM] = pwm_event_flag;
    raw_flag[`IEPR_BIT_CAP] = |capture_flags;
    raw_flag[`IEPR_BIT_PIN] = |pin_flag_group;
    raw_flag[`IEPR_BIT_I2C] = i2c_state_flag | i2c_timeout_flag;
    raw_flag[8+`IEPR_BIT_WAKE] = wake_timer_flag;
    raw_flag[8+`IEPR_BIT_TIMER3] = timer3_overflow_flag;
    raw_flag[8+`IEPR_BIT_UART1] = uart1_tx_flag | uart1_rx_flag;
  end

  assign src_en = {en_b_reg[2:0], en_a_reg};

  // One gate per source: enable bit and global enable together
  genvar gi;
  generate
    for (gi = 0; gi < `IEPR_NSRC; gi++) begin : g_gate
      assign req_next[gi] = raw_flag[gi] & src_en[gi]
        & global_irq_en;
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_req <= `IEPR_RST_SRC;
      req_prev_reg <= `IEPR_RST_SRC;
    end else begin
      src_req <= req_next;
      req_prev_reg <= req_next;
    end
  end

  // Level per core source, high bit on top
  logic [2*`IEPR_NCORE-1:0] level_next;
  generate
    for (gi = 0; gi < `IEPR_NCORE; gi++) begin : g_level
      assign level_next[2*gi+1:2*gi] = {prio_hi_reg[gi],
        prio_lo_reg[gi]};
    end
  endgenerate

  // One process owns the whole level vector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_level <= '0;
    end else begin
      core_level <= level_next;
    end
  end

  // Bus phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= iepr_pkg::IEPR_ADDR;
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else begin
      phase_reg <= acc ? iepr_pkg::IEPR_DATA : iepr_pkg::IEPR_ADDR;
      wr_pend_reg <= acc && hwrite;
      if (acc) begin
        addr_reg <= {haddr[11:2], 2'b00};
      end
    end
  end

  // Enable and priority registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_a_reg <= `IEPR_RST_BYTE;
      en_b_reg <= `IEPR_RST_BYTE;
      prio_hi_reg <= `IEPR_RST_BYTE;
      prio_lo_reg <= `IEPR_RST_BYTE;
      global_irq_en <= 1'b0;
      mask_reg <= `IEPR_RST_SRC;
    end else if (wr_pend_reg) begin
      if (addr_reg == `IEPR_ADDR_EN_A) begin
        en_a_reg <= hwdata[7:0] & `IEPR_EN_A_MASK;
      end else if (addr_reg == `IEPR_ADDR_EN_B) begin
        en_b_reg <= hwdata[7:0] & `IEPR_EN_B_MASK;
      end else if (addr_reg == `IEPR_ADDR_PRIO_HI) begin
        prio_hi_reg <= hwdata[7:0] & `IEPR_PRIO_MASK;
      end else if (addr_reg == `IEPR_ADDR_PRIO_LO) begin
        prio_lo_reg <= hwdata[7:0] & `IEPR_PRIO_MASK;
      end else if (addr_reg == `IEPR_OFS_CTRL) begin
        global_irq_en <= hwdata[`IEPR_BIT_GLOBAL];
      end else if (addr_reg == `IEPR_OFS_MASK) begin
        mask_reg <= hwdata[`IEPR_NSRC-1:0];
      end
    end
  end

  // Sticky status on each rising request; a new event beats a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= `IEPR_RST_SRC;
    end else begin
      if (wr_pend_reg && addr_reg == `IEPR_OFS_STAT) begin
        stat_reg <= (stat_reg & ~hwdata[`IEPR_NSRC-1:0])
          | (req_next & ~req_prev_reg);
      end else begin
        stat_reg <= stat_reg | (req_next & ~req_prev_reg);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (haddr == `IEPR_ADDR_EN_A) begin
      rd_next = {24'h000000, en_a_reg};
    end else if (haddr == `IEPR_ADDR_EN_B) begin
      rd_next = {24'h000000, en_b_reg};
    end else if (haddr == `IEPR_ADDR_PRIO_HI) begin
      rd_next = {24'h000000, prio_hi_reg};
    end else if (haddr == `IEPR_ADDR_PRIO_LO) begin
      rd_next = {24'h000000, prio_lo_reg};
    end else if (haddr == `IEPR_OFS_CTRL) begin
      rd_next = {31'h0000_0000, global_irq_en};
    end else if (haddr == `IEPR_OFS_STAT) begin
      rd_next = {21'h000000, stat_reg};
    end else if (haddr == `IEPR_OFS_MASK) begin
      rd_next = {21'h000000, mask_reg};
    end else if (haddr == `IEPR_OFS_REQ) begin
      rd_next = {21'h000000, req_next};
    end else if (haddr == `IEPR_OFS_LEVEL) begin
      rd_next = {18'h00000, core_level};
    end
  end

  // Read data captured at the address phase, so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (acc && !hwrite) begin
        hrdata <= rd_next;
      end
    end
  end

  // Both directions per source except wake timer and timer 3, which are checked only for a gate stuck open
  a_global_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !global_irq_en |=> src_req == '0)
    else $error("request seen with global enable low");

  a_timer2_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[7] |-> $past(en_a_reg[7] && timer2_overflow_flag))
    else $error("timer 2 request without enable and flag");

  a_timer2_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (global_irq_en && en_a_reg[7] && timer2_overflow_flag) |=> src_req[7])
    else $error("timer 2 overflow not forwarded");

  a_spi_or: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (global_irq_en && en_a_reg[6] && spi_mode_fault) |=> src_req[6])
    else $error("spi mode fault not forwarded");

  a_spi_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[6] |-> $past(en_a_reg[6] && (spi_done_flag || spi_overrun_flag
      || spi_mode_fault)))
    else $error("spi request without enable and flag");

  a_brake_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[5] |-> $past(en_a_reg[5] && brake_fault_flag))
    else $error("brake request without enable and flag");

  a_brake_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (global_irq_en && en_a_reg[5] && brake_fault_flag) |=> src_req[5])
    else $error("brake fault not forwarded");

  a_wdt_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[4] |-> $past(en_a_reg[4] && watchdog_flag))
    else $error("watchdog request without enable and flag");

  a_wdt_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (global_irq_en && en_a_reg[4] && watchdog_flag) |=> src_req[4])
    else $error("watchdog flag not forwarded");

  a_pwm_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[3] |-> $past(en_a_reg[3] && pwm_event_flag))
    else $error("pwm request without enable and flag");

  a_pwm_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (global_irq_en && en_a_reg[3] && pwm_event_flag) |=> src_req[3])
    else $error("pwm flag not forwarded");

  a_cap_any: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (global_irq_en && en_a_reg[2] && capture_flags[2]) |=> src_req[2])
    else $error("capture channel 2 not forwarded");

  a_cap_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[2] |-> $past(en_a_reg[2] && (|capture_flags)))
    else $error("capture request without enable and flag");

  a_pin_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[1] |-> $past(en_a_reg[1] && (|pin_flag_group)))
    else $error("pin request without enable and flag");

  a_pin_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (global_irq_en && en_a_reg[1] && (|pin_flag_group)) |=> src_req[1])
    else $error("pin flag not forwarded");

  a_i2c_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[0] |-> $past(en_a_reg[0] && (i2c_state_flag || i2c_timeout_flag)))
    else $error("i2c request without enable and flag");

  a_i2c_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (global_irq_en && en_a_reg[0] && i2c_timeout_flag) |=> src_req[0])
    else $error("i2c timeout not forwarded");

  a_en_b_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    en_b_reg[7:3] == 5'h00)
    else $error("unimplemented enable b bits set");

  a_wake_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[10] |-> $past(en_b_reg[2] && wake_timer_flag))
    else $error("wake timer request without enable and flag");

  a_timer3_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[9] |-> $past(en_b_reg[1] && timer3_overflow_flag))
    else $error("timer 3 request without enable and flag");

  a_uart1_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    src_req[8] |-> $past(en_b_reg[0] && (uart1_tx_flag || uart1_rx_flag)))
    else $error("uart1 request without enable and flag");

  a_uart1_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (global_irq_en && en_b_reg[0] && uart1_rx_flag) |=> src_req[8])
    else $error("uart1 receive flag not forwarded");

  a_prio_lo_b7: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !prio_lo_reg[7] && !prio_hi_reg[7])
    else $error("priority bit 7 set");

  a_level_pair: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 core_level[13:12] == {$past(prio_hi_reg[6]), $past(prio_lo_reg[6])})
    else $error("adc level mismatch");

  a_level_ext0: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 core_level[1:0] == {$past(prio_hi_reg[0]), $past(prio_lo_reg[0])})
    else $error("external 0 level mismatch");

  a_irq_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq |-> $past(|(stat_reg & mask_reg)))
    else $error("irq without cause");

  a_irq_raise: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|(stat_reg & mask_reg)) |=> irq)
    else $error("unmasked status without irq");

  a_wr_phase: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_reg |-> phase_reg == iepr_pkg::IEPR_DATA)
    else $error("write pending outside data phase");

  a_okay_resp: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hresp)
    else $error("error response driven");
endmodule

/* File: verification/iepr_flag_src.sv */
// Peripheral flag sources that face the enable/priority block
`timescale 1ns/1ps
module iepr_flag_src #(
  parameter int PIN_W = 8 // Width of the pin flag group
) (
  input wire logic [10:0] src_on, // One bit per request line
  input wire logic [1:0] alt, // Which flag drives a shared line
  output logic timer2_overflow_flag, // Timer 2 overflow
  output logic spi_done_flag, // SPI transfer complete
  output logic spi_overrun_flag, // SPI overrun
  output logic spi_mode_fault, // SPI mode fault
  output logic brake_fault_flag, // Fault brake
  output logic watchdog_flag, // Watchdog
  output logic pwm_event_flag, // PWM period
  output logic [2:0] capture_flags, // Capture channels
  output logic [PIN_W-1:0] pin_flag_group, // Pin flags
  output logic i2c_state_flag, // I2C state change
  output logic i2c_timeout_flag, // I2C bus timeout
  output logic wake_timer_flag, // Wake-up timer
  output logic timer3_overflow_flag, // Timer 3 overflow
  output logic uart1_tx_flag, // UART1 transmit done
  output logic uart1_rx_flag // UART1 receive done
);
  logic [2:0] one;
  // Only one flag of a shared line at a time, so each driven OR input is seen alone; pin flags above bit 2 stay low
  assign one = 3'h1 << alt;
  assign timer2_overflow_flag = src_on[7];
  assign spi_done_flag = src_on[6] & one[0];
  assign spi_overrun_flag = src_on[6] & one[1];
  assign spi_mode_fault = src_on[6] & one[2];
  assign brake_fault_flag = src_on[5];
  assign watchdog_flag = src_on[4];
  assign pwm_event_flag = src_on[3];
  assign capture_flags = src_on[2] ? one : 3'h0;
  assign pin_flag_group = src_on[1] ? PIN_W'(one) : '0;
  assign i2c_state_flag = src_on[0] & one[0];
  assign i2c_timeout_flag = src_on[0] & one[1];
  assign uart1_tx_flag = src_on[8] & one[0];
  assign uart1_rx_flag = src_on[8] & one[1];
  assign timer3_overflow_flag = src_on[9];
  assign wake_timer_flag = src_on[10];
endmodule

/* File: verification/iepr_regs_tb.sv */
// Self-checking bench for the enable/priority register block
`timescale 1ns/1ps
`include "iepr_cfg.svh"
module iepr_regs_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0, alt = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [10:0] src_on = 11'h000, src_req;
  logic [13:0] core_level;
  logic hready, hreadyout, hresp, irq;
  logic timer2_overflow_flag, spi_done_flag, spi_overrun_flag, spi_mode_fault;
  logic brake_fault_flag, watchdog_flag, pwm_event_flag, i2c_state_flag;
  logic i2c_timeout_flag, wake_timer_flag, timer3_overflow_flag;
  logic uart1_tx_flag, uart1_rx_flag;
  logic [2:0] capture_flags;
  logic [7:0] pin_flag_group;
  int n_fail = 0, compares = 0;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  iepr_regs u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer2_overflow_flag,
    .spi_done_flag, .spi_overrun_flag, .spi_mode_fault, .brake_fault_flag,
    .watchdog_flag, .pwm_event_flag, .capture_flags, .pin_flag_group,
    .i2c_state_flag, .i2c_timeout_flag, .wake_timer_flag,
    .timer3_overflow_flag, .uart1_tx_flag, .uart1_rx_flag, .src_req,
    .core_level, .irq);
  iepr_flag_src u_src (.src_on, .alt, .timer2_overflow_flag, .spi_done_flag,
    .spi_overrun_flag, .spi_mode_fault, .brake_fault_flag, .watchdog_flag,
    .pwm_event_flag, .capture_flags, .pin_flag_group, .i2c_state_flag,
    .i2c_timeout_flag, .wake_timer_flag, .timer3_overflow_flag,
    .uart1_tx_flag, .uart1_rx_flag);
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // No wait count is assumed: only the watchdog ends a stuck transfer
  task automatic bus(input logic [11:0] a, logic w, logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask
  task automatic rdchk(input logic [11:0] a, logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    chk($sformatf("reg_%h", a), e, x);
    chk("hresp", 32'h0, hresp);
  endtask
  // Printed offsets are word indexes, so the byte address is four times that
  task automatic t_regs();
    logic [11:0] ad[4] = '{`IEPR_OFS_EN_A << 2, `IEPR_OFS_EN_B << 2,
      `IEPR_OFS_PRIO_HI << 2, `IEPR_OFS_PRIO_LO << 2};
    logic [7:0] msk[4] = '{8'hff, 8'h07, 8'h7f, 8'h7f};
    chk("irq", 32'h0, irq);
    chk("level", 32'h0, core_level);
    for (int i = 0; i < 4; i++) begin
      rdchk(ad[i], 32'h0);
      wr(ad[i], 32'hffff_ffff);
      rdchk(ad[i], {24'h0, msk[i]});
      wr(ad[i], 32'h0);
      rdchk(ad[i], 32'h0);
    end
    rdchk(12'h200, 32'h0);
  endtask
  task automatic t_prio();
    logic [7:0] hi = 8'h33, lo = 8'h55;
    logic [13:0] lv;
    wr(`IEPR_OFS_PRIO_LO << 2, {24'h0, lo});
    wr(`IEPR_OFS_PRIO_HI << 2, {24'h0, hi});
    for (int i = 0; i < 7; i++) begin
      lv[2*i+1] = hi[i];
      lv[2*i] = lo[i];
    end
    repeat (2) @(posedge hclk);
    chk("core_level", lv, core_level);
    rdchk(`IEPR_OFS_LEVEL, lv);
  endtask
  task automatic t_gate();
    int na[11] = '{2, 3, 3, 1, 1, 1, 3, 1, 2, 1, 1};
    wr(`IEPR_OFS_CTRL, 32'h1);
    wr(`IEPR_OFS_EN_A << 2, 32'hff);
    wr(`IEPR_OFS_EN_B << 2, 32'h07);
    for (int s = 0; s < 11; s++) begin
      for (int k = 0; k < na[s]; k++) begin
        src_on <= 11'h001 << s;
        alt <= 2'(k);
        repeat (2) @(posedge hclk);
        if (s < 8) chk("req_a", 1 << s, src_req);
        else chk("req_b", 1 << s, src_req);
      end
      wr(`IEPR_OFS_CTRL, 32'h0);
      repeat (2) @(posedge hclk);
      chk("req_global_off", 32'h0, src_req);
      wr(`IEPR_OFS_CTRL, 32'h1);
      if (s < 8) wr(`IEPR_OFS_EN_A << 2, 32'hff ^ (1 << s));
      else wr(`IEPR_OFS_EN_B << 2, 32'h07 ^ (1 << (s - 8)));
      repeat (2) @(posedge hclk);
      chk("req_src_off", 32'h0, src_req);
      wr(`IEPR_OFS_EN_A << 2, 32'hff);
      wr(`IEPR_OFS_EN_B << 2, 32'h07);
    end
    src_on <= 11'h000;
  endtask
  task automatic t_irq();
    wr(`IEPR_OFS_STAT, 32'h7ff);
    wr(`IEPR_OFS_MASK, 32'h80);
    src_on <= 11'h080;
    repeat (3) @(posedge hclk);
    chk("irq_set", 32'h1, irq);
    src_on <= 11'h000;
    wr(`IEPR_OFS_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq_masked", 32'h0, irq);
    rdchk(`IEPR_OFS_STAT, 32'h80);
    wr(`IEPR_OFS_MASK, 32'h80);
    repeat (2) @(posedge hclk);
    chk("irq_sticky", 32'h1, irq);
    wr(`IEPR_OFS_STAT, 32'h80);
    repeat (2) @(posedge hclk);
    chk("irq_cleared", 32'h0, irq);
  endtask
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_prio();
    t_gate();
    t_irq();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    final_report();
  end
endmodule
